//--- bench/lbd_dimmer_sva.sv
// Purpose: Port checks for the backlight dimmer.
// Assumes: SCL phases last at least eight clocks.
// Notes: Bound into every lbd_dimmer.
`timescale 1ns/10ps
module lbd_dimmer_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic bus_busy,
  input wire logic main_bank_enable,
  input wire logic sub_bank_enable,
  input wire logic keypad_enable,
  input wire logic [3:0] main_level_code,
  input wire logic [3:0] sub_level_code,
  input wire logic [1:0] keypad_level_code,
  input wire logic main_sinks,
  input wire logic [6:0] keypad_percent
);
  localparam logic [6:0] PCT [4] = '{7'h14, 7'h28, 7'h46, 7'h64};
  // ==========
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_zero: assert property (disable iff (1'b0) reset |=> !bus_busy && !sda_oe &&
    {main_bank_enable, sub_bank_enable, keypad_enable, main_level_code, sub_level_code, keypad_level_code} == 13'h0)
    else $error("reset left state set");
  a_keypad_pct: assert property (keypad_percent == PCT[keypad_level_code])
    else $error("keypad percent wrong");
  a_sink_off: assert property (!main_bank_enable && $past(!main_bank_enable) |-> !main_sinks)
    else $error("disabled bank pulses");
  a_start_busy: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] bus_busy)
    else $error("start not seen");
  a_stop_free: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] !bus_busy)
    else $error("stop not seen");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved in clock high");
  a_oe_idle: assert property (!bus_busy && !$past(bus_busy) |-> !sda_oe)
    else $error("data driven on free bus");
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("low drive cut short");
  a_reg_quiet: assert property ($changed({main_bank_enable, sub_bank_enable, keypad_enable, main_level_code})
    || $changed({sub_level_code, keypad_level_code}) |-> bus_busy) else $error("register moved off bus");
endmodule : lbd_dimmer_sva
bind lbd_dimmer lbd_dimmer_sva chk_i (.*);

//--- bench/lbd_master.sv
// Purpose: Bus master model driving SCL and SDA.
// Assumes: SDA has a pull-up; sda_m low pulls it down.
// Notes: SCL high half periods of eight clocks in data bits and sixteen in a start, low ones of ten or more.
`timescale 1ns/10ps
module lbd_master (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic start();
    sda_m = 1'b1;
    w(8);
    scl = 1'b1;
    w(8);
    sda_m = 1'b0;
    w(8);
    scl = 1'b0;
    w(8);
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    w(8);
    scl = 1'b1;
    w(8);
    sda_m = 1'b1;
    w(8);
  endtask : stop
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_m = d[i];
      w(8);
      scl = 1'b1;
      w(4);
      q[i] = sda_line;
      w(4);
      scl = 1'b0;
      w(2);
    end
  endtask : xfer
endmodule : lbd_master

//--- bench/tb_led_backlight_i2c_dimming.sv
// Purpose: Self-checking bench of the backlight dimmer.
// Assumes: Both PWM options on one bus, frames of 2000 and 864 clocks.
// Notes: Register model kept in m_en, m_lv and m_kp.
`timescale 1ns/10ps
module tb_led_backlight_i2c_dimming;
  logic clk, reset, scl, sda_m, sda_out, sda_oe, busy, men, sen, ken, msk, ssk, ksk, f_oe, f_sk;
  logic [3:0] mcode, scode;
  logic [1:0] kcode;
  logic [6:0] kpct;
  logic [7:0] m_en, m_lv, m_kp, ofs, d;
  logic [7:0] ofs_tab [4] = '{8'h10, 8'ha0, 8'hb0, 8'h11};
  logic [6:0] pct [4] = '{7'h14, 7'h28, 7'h46, 7'h64};
  int bad_count, check_count;
  wire sda_line = (sda_oe ? sda_out : 1'b1) & sda_m & !f_oe;
  lbd_master bfm (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
  lbd_dimmer uut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_busy(busy), .main_bank_enable(men), .sub_bank_enable(sen), .keypad_enable(ken), .main_level_code(mcode),
    .sub_level_code(scode), .keypad_level_code(kcode), .main_sinks(msk), .sub_sinks(ssk), .keypad_sink(ksk),
    .keypad_percent(kpct));
  lbd_dimmer #(.FAST_OPTION(1'b1)) uut_fast (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe(f_oe), .bus_busy(), .main_bank_enable(), .sub_bank_enable(), .keypad_enable(), .main_level_code(),
    .sub_level_code(), .keypad_level_code(), .main_sinks(f_sk), .sub_sinks(), .keypad_sink(), .keypad_percent());
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========
  // Checking tasks.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    return (a == 8'h10) ? m_en : (a == 8'ha0) ? m_lv : (a == 8'hb0) ? m_kp : 8'h00;
  endfunction : exp_reg
  task automatic chk_out();
    chk(16'({ken, sen, men}), 16'(m_en[2:0]));
    chk(16'({scode, mcode}), 16'(m_lv));
    chk(16'(kcode), 16'(m_kp[1:0]));
    chk(16'(kpct), 16'(pct[m_kp[1:0]]));
    chk(16'(ksk), 16'(m_en[2]));
  endtask : chk_out
  // ==========
  // Bus transfers.
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] v);
    logic [8:0] q;
    bfm.start();
    chk(16'(busy), 16'h1);
    bfm.xfer({dev, 1'b0, 1'b1}, q);
    chk(16'(q[0]), 16'(dev != 7'h36));
    bfm.xfer({a, 1'b1}, q);
    bfm.xfer({v, 1'b1}, q);
    chk(16'(q[0]), 16'(dev != 7'h36));
    bfm.stop();
    chk(16'(busy), 16'h0);
    if (dev == 7'h36 && a == 8'h10) m_en = v & 8'h07;
    if (dev == 7'h36 && a == 8'ha0) m_lv = v;
    if (dev == 7'h36 && a == 8'hb0) m_kp = v & 8'h03;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [8:0] q;
    bfm.start();
    bfm.xfer({7'h36, 1'b0, 1'b1}, q);
    bfm.xfer({a, 1'b1}, q);
    bfm.start();
    bfm.xfer({7'h36, 1'b1, 1'b1}, q);
    chk(16'(q[0]), 16'h0);
    bfm.xfer(9'h1fe, q);
    chk(16'(q[8:1]), 16'(exp_reg(a)));
    bfm.xfer(9'h1ff, q);
    chk(16'(q[8:1]), 16'(exp_reg(a)));
    bfm.stop();
  endtask : rd
  task automatic pwm(input logic [3:0] mc, input logic [3:0] sc);
    int hm, hs, hf, n;
    hm = 0;
    hs = 0;
    hf = 0;
    n = 0;
    wr(7'h36, 8'ha0, {sc, mc});
    repeat (2000) begin
      @(negedge clk);
      hm += int'(msk);
      hs += int'(ssk);
      if (n < 864) hf += int'(f_sk);
      n++;
    end
    chk(16'(hf), 16'((mc + 1) * 54 * m_en[0]));
    chk(16'(hm), 16'((mc + 1) * 125 * m_en[0]));
    chk(16'(hs), 16'((sc + 1) * 125 * m_en[1]));
  endtask : pwm
  // ==========
  // Test sequence.
  initial begin
    #4000000;
    bad_count++;
    wrap_up();
  end
  initial begin
    reset = 1'b1;
    m_en = 8'h00;
    m_lv = 8'h00;
    m_kp = 8'h00;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    void'($urandom(86));
    chk_out();
    for (int i = 0; i < 3; i++) rd(ofs_tab[i]);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      ofs = ofs_tab[i % 4];
      d = 8'($urandom);
      if (ofs == 8'hb0) d[1:0] = 2'(i / 4);
      wr(7'h36, ofs, d);
      chk_out();
      rd(ofs);
    end
    $display("test registers done");
    wr(7'h37, 8'h10, 8'hff);
    chk_out();
    $display("test foreign address done");
    wr(7'h36, 8'h10, 8'h03);
    pwm(4'h0, 4'hf);
    pwm(4'($urandom), 4'($urandom));
    wr(7'h36, 8'h10, 8'h00);
    pwm(4'h7, 4'h7);
    $display("test dimming done");
    wr(7'h36, 8'hb0, 8'h02);
    wr(7'h36, 8'h10, 8'h07);
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    m_en = 8'h00;
    m_lv = 8'h00;
    m_kp = 8'h00;
    chk_out();
    chk(16'({msk, ssk, busy, sda_line}), 16'h1);
    $display("test mid reset done");
    wrap_up();
  end
endmodule : tb_led_backlight_i2c_dimming

//--- verilog/lbd_dimmer.sv
// Purpose: I2C slave with three control registers driving bank PWM and keypad level.
// Assumes: SCL and SDA arrive asynchronously and are synchronised here.
// Notes: SDA is open drain; sda_oe high pulls the line low.
`timescale 1ns/10ps
`include "lbd_regs.svh"
module lbd_dimmer
  import lbd_pkg::*;
#(
  parameter bit FAST_OPTION = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic bus_busy,
  output logic main_bank_enable,
  output logic sub_bank_enable,
  output logic keypad_enable,
  output logic [3:0] main_level_code,
  output logic [3:0] sub_level_code,
  output logic [1:0] keypad_level_code,
  output logic main_sinks,
  output logic sub_sinks,
  output logic keypad_sink,
  output logic [6:0] keypad_percent
);
  localparam int PWM_HZ = FAST_OPTION ? `LBD_PWM_HZ_FAST : `LBD_PWM_HZ_SLOW;
  localparam int TICK_DIV = `LBD_CLK_HZ / (PWM_HZ * `LBD_PWM_STEPS);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    lbd_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic rd;
    logic [7:0] ptr;
    logic busy;
    logic drive_low;
    logic [7:0] enable_r;
    logic [7:0] level_r;
    logic [7:0] keypad_r;
  } lbd_slave_s;

  lbd_slave_s st_reg;
  lbd_slave_s st_next;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl = st_reg.scl_sync[1];
  assign sda = st_reg.sda_sync[1];
  assign scl_rise = scl && !st_reg.scl_d;
  assign scl_fall = !scl && st_reg.scl_d;
  assign start_cond = scl && st_reg.scl_d && st_reg.sda_d && !sda;
  assign stop_cond = scl && st_reg.scl_d && !st_reg.sda_d && sda;

  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] e,
                                          input logic [7:0] l, input logic [7:0] k);
    logic [7:0] r;
    r = 8'h00;
    if (a == `LBD_ENABLE_OFS) r = e;
    else if (a == `LBD_LEVEL_OFS) r = l;
    else if (a == `LBD_KEYPAD_OFS) r = k;
    return r;
  endfunction : read_reg

  // ==========================================================
  // Serial slave and register file.
  always_comb begin
    st_next = st_reg;
    st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
    st_next.scl_d = scl;
    st_next.sda_d = sda;
    if (start_cond) begin
      st_next.busy = 1'b1;
      st_next.state = LBD_RX;
      st_next.bit_cnt = 4'h0;
      st_next.byte_idx = 2'h0;
      st_next.drive_low = 1'b0;
    end else if (stop_cond) begin
      st_next.busy = 1'b0;
      st_next.state = LBD_IDLE;
      st_next.drive_low = 1'b0;
    end else begin
      unique case (st_reg.state)
        LBD_IDLE: begin
          st_next.drive_low = 1'b0;
        end
        LBD_RX: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], sda};
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end
          if (scl_fall && st_reg.bit_cnt == 4'h8) begin
            st_next.bit_cnt = 4'h0;
            if (st_reg.byte_idx == 2'h0) begin
              if (st_reg.shift[7:1] == `LBD_SLAVE_ADDR) begin
                st_next.rd = st_reg.shift[0];
                st_next.state = LBD_ACK;
                st_next.drive_low = 1'b1;
              end else begin
                st_next.state = LBD_IDLE;
              end
            end else begin
              if (st_reg.byte_idx == 2'h1) begin
                st_next.ptr = st_reg.shift;
              end else begin
                if (st_reg.ptr == `LBD_ENABLE_OFS) st_next.enable_r = st_reg.shift & 8'h07;
                else if (st_reg.ptr == `LBD_LEVEL_OFS) st_next.level_r = st_reg.shift;
                else if (st_reg.ptr == `LBD_KEYPAD_OFS) st_next.keypad_r = st_reg.shift & `LBD_KEY_MASK;
              end
              st_next.state = LBD_ACK;
              st_next.drive_low = 1'b1;
            end
          end
        end
        LBD_ACK: begin
          if (scl_fall) begin
            st_next.drive_low = 1'b0;
            if (st_reg.byte_idx != 2'h3) st_next.byte_idx = st_reg.byte_idx + 2'h1;
            if (st_reg.byte_idx == 2'h0 && st_reg.rd) begin
              st_next.shift = read_reg(st_reg.ptr, st_reg.enable_r, st_reg.level_r, st_reg.keypad_r);
              st_next.drive_low = !st_next.shift[7];
              st_next.bit_cnt = 4'h0;
              st_next.state = LBD_TX;
            end else begin
              st_next.state = LBD_RX;
            end
          end
        end
        LBD_TX: begin
          if (scl_fall) begin
            if (st_reg.bit_cnt == 4'h7) begin
              st_next.drive_low = 1'b0;
              st_next.state = LBD_TX_ACK;
            end else begin
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.drive_low = !st_next.shift[7];
              st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end
          end
        end
        LBD_TX_ACK: begin
          if (scl_rise) begin
            st_next.state = sda ? LBD_IDLE : LBD_TX_ACK;
          end
          if (scl_fall && st_reg.state == LBD_TX_ACK) begin
            st_next.shift = read_reg(st_reg.ptr, st_reg.enable_r, st_reg.level_r, st_reg.keypad_r);
            st_next.drive_low = !st_next.shift[7];
            st_next.bit_cnt = 4'h0;
            st_next.state = LBD_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.scl_sync <= 2'h3;
      st_reg.sda_sync <= 2'h3;
      st_reg.scl_d <= 1'b1;
      st_reg.sda_d <= 1'b1;
      st_reg.state <= LBD_IDLE;
      st_reg.enable_r <= `LBD_ENABLE_RST;
      st_reg.level_r <= `LBD_LEVEL_RST;
      st_reg.keypad_r <= `LBD_KEYPAD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs and dimming.
  assign sda_out = 1'b0;
  assign sda_oe = st_reg.drive_low;
  assign bus_busy = st_reg.busy;
  assign main_bank_enable = st_reg.enable_r[`LBD_MAIN_EN_BIT];
  assign sub_bank_enable = st_reg.enable_r[`LBD_SUB_EN_BIT];
  assign keypad_enable = st_reg.enable_r[`LBD_KEY_EN_BIT];
  assign main_level_code = st_reg.level_r[`LBD_MAIN_LSB +: 4];
  assign sub_level_code = st_reg.level_r[`LBD_SUB_LSB +: 4];
  assign keypad_level_code = st_reg.keypad_r[`LBD_KEY_LSB +: 2];
  assign keypad_sink = keypad_enable;

  always_comb begin
    unique case (keypad_level_code)
      2'h0: keypad_percent = 7'h14;
      2'h1: keypad_percent = 7'h28;
      2'h2: keypad_percent = 7'h46;
      2'h3: keypad_percent = 7'h64;
    endcase
  end

  logic [1:0] bank_enable;
  logic [1:0][3:0] bank_code;
  logic [1:0] bank_pwm;

  assign bank_enable = {sub_bank_enable, main_bank_enable};
  assign bank_code = {sub_level_code, main_level_code};
  assign main_sinks = bank_pwm[0];
  assign sub_sinks = bank_pwm[1];

  // ==========================================================
  // One dimming generator per display bank.
  for (genvar b = 0; b < 2; b++) begin : g_bank
    lbd_pwm #(.TICK_DIV(TICK_DIV)) u_pwm (
      .clk(clk),
      .reset(reset),
      .enable(bank_enable[b]),
      .level_code(bank_code[b]),
      .pwm_on(bank_pwm[b])
    );
  end
endmodule : lbd_dimmer

//--- verilog/lbd_pkg.sv
// Purpose: Types shared by the LED backlight dimmer modules.
// Assumes: Constants come from lbd_regs.svh.
// Notes: States of the serial slave.
package lbd_pkg;
  typedef enum logic [2:0] {
    LBD_IDLE,
    LBD_RX,
    LBD_ACK,
    LBD_TX,
    LBD_TX_ACK
  } lbd_state_e;
endpackage : lbd_pkg

//--- verilog/lbd_pwm.sv
// Purpose: Sixteen-step PWM for one display bank.
// Assumes: Tick period sets the PWM frame length.
// Notes: Code n gives a duty of (n+1)/16.
`timescale 1ns/10ps
`include "lbd_regs.svh"
module lbd_pwm
  import lbd_pkg::*;
#(
  parameter int TICK_DIV = 125
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [3:0] level_code,
  output logic pwm_on
);
  initial begin
    if (TICK_DIV < 1 || TICK_DIV > 65535) $error("TICK_DIV out of range");
  end

  typedef struct packed {
    logic [15:0] div;
    logic [3:0] phase;
    logic out;
  } lbd_pwm_s;

  lbd_pwm_s st_reg;
  lbd_pwm_s st_next;

  // ==========================================================
  // Frame counter and compare.
  always_comb begin
    st_next = st_reg;
    if (st_reg.div == 16'(TICK_DIV - 1)) begin
      st_next.div = 16'h0000;
      st_next.phase = st_reg.phase + 4'h1;
    end else begin
      st_next.div = st_reg.div + 16'h0001;
    end
    st_next.out = enable && (st_next.phase <= level_code);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm_on = st_reg.out;
endmodule : lbd_pwm

//--- verilog/lbd_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts of the LED backlight dimmer.
// Assumes: A 20 MHz system clock and an I2C-compatible slave port.
// Notes: Included by the design modules lbd_dimmer and lbd_pwm.
// Summary of operation
// - SDA falling while SCL high is a start condition opening a session.
// - SDA rising while SCL high is a stop condition ending the session.
// - Bus is busy from any start until the next stop.
// - A repeated start restarts address reception like a first start.
// - The data driver changes SDA only while SCL is low.
// - Bytes are eight bits, MSB first, then one acknowledge bit.
// - The device pulls SDA low on the ninth clock after each received byte.
// - First byte is seven address bits then direction bit, 0 write, 1 read.
// - The device answers only slave address 0110110 (hex 36).
// - In a write, second byte selects the register, third byte is stored.
// - Register hex 10 holds main, sub and keypad enable bits.
// - Register hex A0 holds main and sub four-bit level codes.
// - Each level code step adds one sixteenth of full-scale brightness.
// - Banks use PWM with sixteen duties at a fixed 10 or 23 kHz.
// - Register hex B0 holds a two-bit keypad code; 11 is full scale.
// - Bits seven to two of the keypad register have no function.
// - Keypad is dimmed by analog scaling to 100, 70, 40 or 20 percent.
// - All three registers reset to zero, drivers disabled.
`ifndef LBD_REGS_SVH
`define LBD_REGS_SVH
`define LBD_SLAVE_ADDR 7'h36
`define LBD_ENABLE_OFS 8'h10
`define LBD_LEVEL_OFS 8'ha0
`define LBD_KEYPAD_OFS 8'hb0
`define LBD_ENABLE_RST 8'h00
`define LBD_LEVEL_RST 8'h00
`define LBD_KEYPAD_RST 8'h00
`define LBD_MAIN_EN_BIT 0
`define LBD_SUB_EN_BIT 1
`define LBD_KEY_EN_BIT 2
`define LBD_MAIN_LSB 0
`define LBD_SUB_LSB 4
`define LBD_KEY_LSB 0
`define LBD_KEY_MASK 8'h03
`define LBD_CLK_HZ 20000000
`define LBD_PWM_HZ_SLOW 10000
`define LBD_PWM_HZ_FAST 23000
`define LBD_PWM_STEPS 16
`endif
